//--- verilog/ism_pkg.sv
// Constants and types shared by the information status monitor files.
package ism_pkg;
   localparam int NUM_NOTICE = 11;
   localparam int CMP_NUM    = 6;
   localparam int VAL_W      = 16;
   localparam int HIST_DEPTH = 16;
   localparam int IDX_W      = 4;
   localparam int CNT_W      = 5;
   localparam int CODE_W     = 4;
   localparam int TIME_W     = 32;
   localparam int IO_W       = 8;
   localparam int IO_SEL_W   = 3;
   localparam int TICK_W     = 32;
   localparam int OL_W       = 16;

   // Bit positions of the notices in the flag vector; the history code is position plus one.
   localparam int N_USRIO  = 0;
   localparam int N_POSERR = 1;
   localparam int N_DRVTMP = 2;
   localparam int N_MTRTMP = 3;
   localparam int N_OVOLT  = 4;
   localparam int N_UVOLT  = 5;
   localparam int N_OLTIME = 6;
   localparam int N_SPD    = 7;
   localparam int N_START  = 8;
   localparam int N_HOME_REQUEST_INPUT  = 9;
   localparam int N_PRREQ  = 10;

   // Comparator slots of the measured quantities.
   localparam int C_POSERR = 0;
   localparam int C_DRVTMP = 1;
   localparam int C_MTRTMP = 2;
   localparam int C_OVOLT  = 3;
   localparam int C_UVOLT  = 4;
   localparam int C_SPD    = 5;
   localparam logic [CMP_NUM-1:0] CMP_BELOW = 6'h10;

   localparam logic [NUM_NOTICE-1:0] ACTION_RST = 11'h7FF;

   localparam int CLK_PERIOD_PS   = 4000;
   localparam int TICK_PERIOD_NS  = 1000000;
   localparam int TICK_CYCLES     = TICK_PERIOD_NS * 1000 / CLK_PERIOD_PS;
   localparam int BLINK_PERIOD_MS = 500;
   localparam int BLINK_TICKS     = BLINK_PERIOD_MS * 1000000 / TICK_PERIOD_NS;

   typedef struct packed {
      logic [CODE_W-1:0]     code;
      logic [TIME_W-1:0]     stamp;
      logic [NUM_NOTICE-1:0] contents;
   } ism_rec_t;
endpackage : ism_pkg

//--- verilog/ism_threshold.sv
// Registered threshold comparator for one measured quantity.
`timescale 1ns/100ps
module ism_threshold #(
   parameter logic BELOW = 1'b0
) (
   input  wire logic                      clk,
   input  wire logic                      rstSync_b,
   input  wire logic [ism_pkg::VAL_W-1:0] value,
   input  wire logic [ism_pkg::VAL_W-1:0] limit,
   output wire logic                      flag
);
   typedef struct packed {
      logic flag;
   } ism_thr_st_t;

   ism_thr_st_t st_r;
   ism_thr_st_t st_nxt;
   logic        over;
   logic        under;

   // Equal to the limit holds the flag, so a value sitting on it does not chatter.
   always_comb begin
      over   = BELOW ? (value < limit) : (value > limit);
      under  = BELOW ? (value > limit) : (value < limit);
      st_nxt = st_r;
      if (over) begin
         st_nxt.flag = 1'b1;
      end else if (under) begin
         st_nxt.flag = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rstSync_b) begin
      if (!rstSync_b) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign flag = st_r.flag;

   property p_thr_set;
      @(posedge clk) disable iff (!rstSync_b) over |=> flag;
   endproperty
   a_thr_set: assert property (p_thr_set) else $error("notice not set past threshold");

   property p_thr_clr;
      @(posedge clk) disable iff (!rstSync_b) under |=> !flag;
   endproperty
   a_thr_clr: assert property (p_thr_clr) else $error("notice not cleared past threshold");
endmodule : ism_threshold

//--- verilog/ism_history.sv
// Sixteen-entry notice history, newest first, with read port and clear.
`timescale 1ns/100ps
module ism_history (
   input  wire logic                      clk,
   input  wire logic                      rstSync_b,
   input  wire logic                      push,
   input  wire ism_pkg::ism_rec_t         pushRec,
   input  wire logic                      clear,
   input  wire logic                      rdReq,
   input  wire logic [ism_pkg::IDX_W-1:0] rdIdx,
   output wire logic                      rdValid,
   output wire logic                      rdHit,
   output wire ism_pkg::ism_rec_t         rdRec,
   output wire logic [ism_pkg::CNT_W-1:0] count
);
   typedef struct packed {
      ism_pkg::ism_rec_t [ism_pkg::HIST_DEPTH-1:0] recs;
      logic [ism_pkg::CNT_W-1:0]                   count;
      logic                                        rdValid;
      logic                                        rdHit;
      ism_pkg::ism_rec_t                           rdRec;
   } ism_hist_st_t;

   ism_hist_st_t st_r;
   ism_hist_st_t st_nxt;

   always_comb begin
      st_nxt = st_r;
      st_nxt.rdValid = rdReq;
      if (rdReq) begin
         st_nxt.rdHit = {1'b0, rdIdx} < st_r.count;
         st_nxt.rdRec = st_nxt.rdHit ? st_r.recs[rdIdx] : '0;
      end
      // A record pushed in the clearing cycle survives the clear.
      if (clear) begin
         st_nxt.count = '0;
      end
      if (push) begin
         for (int i = ism_pkg::HIST_DEPTH - 1; i > 0; i--) begin
            st_nxt.recs[i] = st_r.recs[i-1];
         end
         st_nxt.recs[0] = pushRec;
         if (st_nxt.count != ism_pkg::CNT_W'(ism_pkg::HIST_DEPTH)) begin
            st_nxt.count = st_nxt.count + 5'h01;
         end
      end
   end

   // Loss of control power lands here as reset, which empties the store.
   always_ff @(posedge clk or negedge rstSync_b) begin
      if (!rstSync_b) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign rdValid = st_r.rdValid;
   assign rdHit   = st_r.rdHit;
   assign rdRec   = st_r.rdRec;
   assign count   = st_r.count;

   property p_hist_clear;
      @(posedge clk) disable iff (!rstSync_b) (clear && !push) |=> count == 5'h00;
   endproperty
   a_hist_clear: assert property (p_hist_clear) else $error("history not emptied by clear");

   property p_hist_cap;
      @(posedge clk) disable iff (!rstSync_b) (push && count == 5'h10 && !clear) |=> count == 5'h10;
   endproperty
   a_hist_cap: assert property (p_hist_cap) else $error("history depth exceeded or lost");

   property p_hist_read;
      @(posedge clk) disable iff (!rstSync_b) (rdReq && !push && !clear && rdIdx == 4'h0 && count != 5'h00)
         |=> rdValid && rdHit && rdRec == $past(st_r.recs[0]);
   endproperty
   a_hist_read: assert property (p_hist_read) else $error("history read not answered next cycle");
endmodule : ism_history

//--- verilog/ism_info_monitor.sv
// Information status monitor: notice flags, summary output and notice history.
`timescale 1ns/100ps
module ism_info_monitor #(
   parameter int TICK_CYCLES = ism_pkg::TICK_CYCLES
) (
   input  wire logic                                               clk,
   input  wire logic                                               rst_b,
   input  wire logic [ism_pkg::IO_W-1:0]                           ioBus,
   input  wire logic [ism_pkg::IO_SEL_W-1:0]                       ioSel,
   input  wire logic [ism_pkg::CMP_NUM-1:0][ism_pkg::VAL_W-1:0]    measVal,
   input  wire logic [ism_pkg::CMP_NUM-1:0][ism_pkg::VAL_W-1:0]    measLimit,
   input  wire logic                                               overloadIn,
   input  wire logic [ism_pkg::OL_W-1:0]                           olTimeLimit,
   input  wire logic                                               startReq,
   input  wire logic                                               startDirRev,
   input  wire logic                                               readyIn,
   input  wire logic                                               forwardBlockInput,
   input  wire logic                                               reverseBlockInput,
   input  wire logic                                               forwardLimitSwitch,
   input  wire logic                                               reverseLimitSwitch,
   input  wire logic                                               fwdSoftLimit,
   input  wire logic                                               revSoftLimit,
   input  wire logic                                               homeRequestInput,
   input  wire logic                                               coordinateValid,
   input  wire logic                                               electricalHomeSelectInput,
   input  wire logic                                               presetTrig,
   input  wire logic                                               presetDone,
   input  wire logic [ism_pkg::NUM_NOTICE-1:0]                     actionSel,
   input  wire logic                                               monReq,
   input  wire logic [ism_pkg::IDX_W-1:0]                          monIdx,
   input  wire logic                                               maintClear,
   output wire logic                                               monValid,
   output wire logic                                               monHit,
   output wire logic [ism_pkg::CODE_W-1:0]                         monCode,
   output wire logic [ism_pkg::TIME_W-1:0]                         monStamp,
   output wire logic [ism_pkg::NUM_NOTICE-1:0]                     monContents,
   output wire logic [ism_pkg::CNT_W-1:0]                          histCount,
   output wire logic [ism_pkg::NUM_NOTICE-1:0]                     noticeFlags,
   output wire logic                                               infoOut,
   output wire logic                                               ledBlink
);
   typedef struct packed {
      logic                               usrio;
      logic                               oltime;
      logic                               startErr;
      logic                               homeErr;
      logic                               preset;
      logic [ism_pkg::OL_W-1:0]           olCnt;
      logic [ism_pkg::TICK_W-1:0]         tickCnt;
      logic [ism_pkg::TIME_W-1:0]         stamp;
      logic [ism_pkg::TICK_W-1:0]         blinkCnt;
      logic                               blink;
      logic [ism_pkg::NUM_NOTICE-1:0]     prev;
      logic [ism_pkg::NUM_NOTICE-1:0]     pend;
      logic                               push;
      ism_pkg::ism_rec_t                  rec;
   } ism_mon_st_t;

   ism_mon_st_t                      st_r;
   ism_mon_st_t                      st_nxt;
   logic                             rstMeta_r;
   logic                             rstSync_r;
   logic [ism_pkg::CMP_NUM-1:0]      cmpFlag;
   logic [ism_pkg::NUM_NOTICE-1:0]   notice;
   logic [ism_pkg::NUM_NOTICE-1:0]   waiting;
   logic [ism_pkg::CODE_W-1:0]       pick;
   logic                             tick;
   logic                             selIo;
   logic                             blocked;
   logic                             homeBad;
   logic                             startBad;
   logic                             normalStart;
   ism_pkg::ism_rec_t                rdRec;

   // Lowest set bit wins, so simultaneous notices are logged in a fixed order.
   function automatic logic [ism_pkg::CODE_W-1:0] ism_lowest(
      input logic [ism_pkg::NUM_NOTICE-1:0] v
   );
      ism_lowest = '0;
      for (int i = ism_pkg::NUM_NOTICE - 1; i >= 0; i--) begin
         if (v[i]) begin
            ism_lowest = ism_pkg::CODE_W'(i);
         end
      end
   endfunction : ism_lowest

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rstMeta_r <= 1'b0;
         rstSync_r <= 1'b0;
      end else begin
         rstMeta_r <= 1'b1;
         rstSync_r <= rstMeta_r;
      end
   end

   genvar g;
   generate
      for (g = 0; g < ism_pkg::CMP_NUM; g++) begin : gCmp
         ism_threshold #(
            .BELOW (ism_pkg::CMP_BELOW[g])
         ) uThr (
            .clk       (clk),
            .rstSync_b (rstSync_r),
            .value     (measVal[g]),
            .limit     (measLimit[g]),
            .flag      (cmpFlag[g])
         );
      end
   endgenerate

   always_comb begin
      notice                     = '0;
      notice[ism_pkg::N_USRIO]   = st_r.usrio;
      notice[ism_pkg::N_POSERR]  = cmpFlag[ism_pkg::C_POSERR];
      notice[ism_pkg::N_DRVTMP]  = cmpFlag[ism_pkg::C_DRVTMP];
      notice[ism_pkg::N_MTRTMP]  = cmpFlag[ism_pkg::C_MTRTMP];
      notice[ism_pkg::N_OVOLT]   = cmpFlag[ism_pkg::C_OVOLT];
      notice[ism_pkg::N_UVOLT]   = cmpFlag[ism_pkg::C_UVOLT];
      notice[ism_pkg::N_OLTIME]  = st_r.oltime;
      notice[ism_pkg::N_SPD]     = cmpFlag[ism_pkg::C_SPD];
      notice[ism_pkg::N_START]   = st_r.startErr;
      notice[ism_pkg::N_HOME_REQUEST_INPUT]   = st_r.homeErr;
      notice[ism_pkg::N_PRREQ]   = st_r.preset;
   end

   assign tick     = st_r.tickCnt == ism_pkg::TICK_W'(TICK_CYCLES - 1);
   assign selIo    = ioBus[ioSel];
   assign blocked  = !readyIn || (startDirRev ?
                     (reverseBlockInput || reverseLimitSwitch || revSoftLimit) :
                     (forwardBlockInput || forwardLimitSwitch || fwdSoftLimit));
   assign homeBad  = !coordinateValid || electricalHomeSelectInput;
   assign startBad = (startReq && blocked) || (homeRequestInput && !readyIn);
   assign normalStart = (startReq && !blocked) || (homeRequestInput && readyIn && !homeBad);
   assign waiting  = st_r.pend | (notice & ~st_r.prev);
   assign pick     = ism_lowest(waiting);

   always_comb begin
      st_nxt = st_r;
      st_nxt.tickCnt = tick ? '0 : st_r.tickCnt + 32'h0000_0001;
      if (tick) begin
         st_nxt.stamp = st_r.stamp + 32'h0000_0001;
      end

      st_nxt.usrio = selIo;

      // Overload time is counted in ticks; recovery winds the count back down.
      if (tick) begin
         if (overloadIn) begin
            if (st_r.olCnt != 16'hFFFF) begin
               st_nxt.olCnt = st_r.olCnt + 16'h0001;
            end
         end else if (st_r.olCnt != 16'h0000) begin
            st_nxt.olCnt = st_r.olCnt - 16'h0001;
         end
      end
      if (st_r.olCnt > olTimeLimit) begin
         st_nxt.oltime = 1'b1;
      end else if (st_r.olCnt < olTimeLimit) begin
         st_nxt.oltime = 1'b0;
      end

      if (startBad) begin
         st_nxt.startErr = 1'b1;
      end else if (normalStart) begin
         st_nxt.startErr = 1'b0;
      end

      if (homeRequestInput && homeBad) begin
         st_nxt.homeErr = 1'b1;
      end else if (normalStart) begin
         st_nxt.homeErr = 1'b0;
      end

      if (presetTrig) begin
         st_nxt.preset = 1'b1;
      end else if (presetDone) begin
         st_nxt.preset = 1'b0;
      end

      if (tick) begin
         if (st_r.blinkCnt == ism_pkg::TICK_W'(ism_pkg::BLINK_TICKS - 1)) begin
            st_nxt.blinkCnt = '0;
            st_nxt.blink    = !st_r.blink;
         end else begin
            st_nxt.blinkCnt = st_r.blinkCnt + 32'h0000_0001;
         end
      end

      // One record per cycle; further rising notices wait in the pending mask.
      st_nxt.prev = notice;
      st_nxt.push = |waiting;
      st_nxt.pend = waiting;
      if (|waiting) begin
         st_nxt.pend[pick]     = 1'b0;
         st_nxt.rec.code       = pick + 4'h1;
         st_nxt.rec.stamp      = st_r.stamp;
         st_nxt.rec.contents   = notice;
      end
   end

   always_ff @(posedge clk or negedge rstSync_r) begin
      if (!rstSync_r) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   ism_history uHist (
      .clk       (clk),
      .rstSync_b (rstSync_r),
      .push      (st_r.push),
      .pushRec   (st_r.rec),
      .clear     (maintClear),
      .rdReq     (monReq),
      .rdIdx     (monIdx),
      .rdValid   (monValid),
      .rdHit     (monHit),
      .rdRec     (rdRec),
      .count     (histCount)
   );

   assign monCode     = rdRec.code;
   assign monStamp    = rdRec.stamp;
   assign monContents = rdRec.contents;
   assign noticeFlags = notice;
   assign infoOut     = |(notice & actionSel);
   assign ledBlink    = infoOut && st_r.blink;

   property p_usrio;
      @(posedge clk) disable iff (!rstSync_r) 1'b1 |=> noticeFlags[ism_pkg::N_USRIO] == $past(selIo);
   endproperty
   a_usrio: assert property (p_usrio) else $error("assigned I/O notice does not follow selected signal");

   property p_start_set;
      @(posedge clk) disable iff (!rstSync_r) (startReq && blocked) |=> noticeFlags[ism_pkg::N_START];
   endproperty
   a_start_set: assert property (p_start_set) else $error("start error notice not set");

   property p_home_set;
      @(posedge clk) disable iff (!rstSync_r)
         (homeRequestInput && homeBad) |=> noticeFlags[ism_pkg::N_HOME_REQUEST_INPUT];
   endproperty
   a_home_set: assert property (p_home_set) else $error("home start error notice not set");

   property p_home_clr;
      @(posedge clk) disable iff (!rstSync_r)
         (normalStart && !(homeRequestInput && homeBad)) |=> !noticeFlags[ism_pkg::N_HOME_REQUEST_INPUT];
   endproperty
   a_home_clr: assert property (p_home_clr) else $error("home start error not cleared by normal start");

   property p_preset;
      @(posedge clk) disable iff (!rstSync_r)
         (presetDone && !presetTrig) |=> !noticeFlags[ism_pkg::N_PRREQ];
   endproperty
   a_preset: assert property (p_preset) else $error("preset request notice not cleared");

   property p_log;
      @(posedge clk) disable iff (!rstSync_r)
         $rose(noticeFlags[ism_pkg::N_USRIO]) |=> st_r.push;
   endproperty
   a_log: assert property (p_log) else $error("rising notice not logged");

   property p_olt_set;
      @(posedge clk) disable iff (!rstSync_r)
         (st_r.olCnt > olTimeLimit) |=> noticeFlags[ism_pkg::N_OLTIME];
   endproperty
   a_olt_set: assert property (p_olt_set) else $error("overload time notice not set");

   property p_olt_clr;
      @(posedge clk) disable iff (!rstSync_r)
         (st_r.olCnt < olTimeLimit) |=> !noticeFlags[ism_pkg::N_OLTIME];
   endproperty
   a_olt_clr: assert property (p_olt_clr) else $error("overload time notice not cleared");

   property p_start_clr;
      @(posedge clk) disable iff (!rstSync_r)
         (normalStart && !startBad) |=> !noticeFlags[ism_pkg::N_START];
   endproperty
   a_start_clr: assert property (p_start_clr) else $error("start error not cleared by normal start");

   property p_start_hold;
      @(posedge clk) disable iff (!rstSync_r)
         (!startBad && !normalStart) |=> $stable(noticeFlags[ism_pkg::N_START]);
   endproperty
   a_start_hold: assert property (p_start_hold) else $error("start error notice changed without cause");

   property p_preset_set;
      @(posedge clk) disable iff (!rstSync_r)
         presetTrig |=> noticeFlags[ism_pkg::N_PRREQ];
   endproperty
   a_preset_set: assert property (p_preset_set) else $error("preset request notice not set");

   property p_preset_hold;
      @(posedge clk) disable iff (!rstSync_r)
         (!presetTrig && !presetDone) |=> $stable(noticeFlags[ism_pkg::N_PRREQ]);
   endproperty
   a_preset_hold: assert property (p_preset_hold) else $error("preset request notice changed without cause");

   property p_rec_contents;
      @(posedge clk) disable iff (!rstSync_r)
         st_r.push |-> st_r.rec.contents == $past(notice);
   endproperty
   a_rec_contents: assert property (p_rec_contents) else $error("record contents differ from flags");

   property p_rec_code;
      @(posedge clk) disable iff (!rstSync_r)
         st_r.push |-> (st_r.rec.code != 4'h0) && (st_r.rec.code <= ism_pkg::CODE_W'(ism_pkg::NUM_NOTICE));
   endproperty
   a_rec_code: assert property (p_rec_code) else $error("record code out of range");

   property p_stamp;
      @(posedge clk) disable iff (!rstSync_r)
         tick |=> st_r.stamp == $past(st_r.stamp) + 32'h0000_0001;
   endproperty
   a_stamp: assert property (p_stamp) else $error("time stamp did not advance on tick");

   property p_count_step;
      @(posedge clk) disable iff (!rstSync_r)
         (st_r.push && !maintClear && histCount != 5'h10) |=> histCount == $past(histCount) + 5'h01;
   endproperty
   a_count_step: assert property (p_count_step) else $error("history count did not grow by one");

   property p_count_max;
      @(posedge clk) disable iff (!rstSync_r)
         histCount <= 5'h10;
   endproperty
   a_count_max: assert property (p_count_max) else $error("history count above depth");
endmodule : ism_info_monitor

//--- tb/ism_host_model.sv
// Network host model that issues history read and history clear commands.
`timescale 1ns/100ps
module ism_host_model (
   input  wire logic                      clk,
   input  wire logic                      monValid,
   output logic                           monReq,
   output logic [ism_pkg::IDX_W-1:0]      monIdx,
   output logic                           maintClear
);
   initial begin
      monReq     = 1'b0;
      monIdx     = 4'hF;
      maintClear = 1'b0;
   end

   // The index is scrambled after release so a stale value can never pass for a held one.
   task automatic read_rec(input logic [ism_pkg::IDX_W-1:0] idx, output logic ok);
      @(negedge clk);
      monReq = 1'b1;
      monIdx = idx;
      @(negedge clk);
      ok     = monValid;
      monReq = 1'b0;
      monIdx = ~idx;
   endtask : read_rec

   task automatic clear_hist();
      @(negedge clk);
      maintClear = 1'b1;
      @(negedge clk);
      maintClear = 1'b0;
   endtask : clear_hist
endmodule : ism_host_model

//--- tb/test_ism_info_monitor.sv
// Self-checking bench of the information status monitor.
`timescale 1ns/100ps
module test_ism_info_monitor;
   logic        clk, rst_b, overloadIn, startReq, startDirRev, readyIn, homeReq, coordValid, elHome;
   logic        presetTrig, presetDone, ok, monValid, monHit, infoOut, ledBlink, monReq, maintClear;
   logic [5:0]  stopIn;
   logic [7:0]  ioBus;
   logic [2:0]  ioSel;
   logic [3:0]  monIdx, monCode;
   logic [4:0]  histCount;
   logic [10:0] actionSel, monContents, noticeFlags;
   logic [15:0] olTimeLimit, v, l;
   logic [31:0] r, s0, monStamp;
   logic [5:0][15:0] measVal, measLimit;
   int          seed, errTotal, samplesChecked, cycles, blinkHigh;

   ism_info_monitor #(.TICK_CYCLES(4)) i_ism_info_monitor (.clk(clk), .rst_b(rst_b), .ioBus(ioBus),
      .ioSel(ioSel), .measVal(measVal), .measLimit(measLimit), .overloadIn(overloadIn),
      .olTimeLimit(olTimeLimit), .startReq(startReq), .startDirRev(startDirRev), .readyIn(readyIn),
      .forwardBlockInput(stopIn[0]), .reverseBlockInput(stopIn[1]), .forwardLimitSwitch(stopIn[2]),
      .reverseLimitSwitch(stopIn[3]), .fwdSoftLimit(stopIn[4]), .revSoftLimit(stopIn[5]),
      .homeRequestInput(homeReq), .coordinateValid(coordValid), .electricalHomeSelectInput(elHome),
      .presetTrig(presetTrig), .presetDone(presetDone), .actionSel(actionSel), .monReq(monReq),
      .monIdx(monIdx), .maintClear(maintClear), .monValid(monValid), .monHit(monHit), .monCode(monCode),
      .monStamp(monStamp), .monContents(monContents), .histCount(histCount), .noticeFlags(noticeFlags),
      .infoOut(infoOut), .ledBlink(ledBlink));

   ism_host_model i_ism_host_model (.clk(clk), .monValid(monValid), .monReq(monReq), .monIdx(monIdx),
      .maintClear(maintClear));

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   function automatic logic start_bad(input logic rdy, input logic rev, input logic [5:0] s);
      return !rdy || (rev ? |(s & 6'h2A) : |(s & 6'h15));
   endfunction : start_bad

   task automatic step(input int n);
      repeat (n) @(negedge clk);
   endtask : step

   task automatic chk(input logic [31:0] exp, input logic [31:0] got);
      samplesChecked++;
      if (got !== exp) begin
         errTotal++;
         $display("ERROR t=%0t exp=%h got=%h", $time, exp, got);
      end
   endtask : chk

   task automatic pulse(ref logic s);
      s = 1'b1;
      step(1);
      s = 1'b0;
      step(3);
   endtask : pulse

   task automatic end_of_test();
      $display("Comparisons %0d mismatches %0d", samplesChecked, errTotal);
      if (errTotal == 0 && samplesChecked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : end_of_test

   // The ceiling is several times the expected run length.
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         errTotal++;
         end_of_test();
      end
   end

   initial begin
      seed = 16;
      {rst_b, overloadIn, startReq, startDirRev, homeReq, elHome, presetTrig, presetDone} = 8'h00;
      {readyIn, coordValid, stopIn, ioBus, ioSel} = 19'h30000;
      {measVal, measLimit} = '0;
      olTimeLimit = 16'h0002;
      actionSel = 11'h7FF;
      step(6);
      rst_b = 1'b1;
      step(4);
      chk(0, histCount);
      chk(0, noticeFlags);
      for (int k = 0; k < 6; k++) begin
         for (int t = 0; t < 4; t++) begin
            r = $random(seed);
            v = {1'b0, r[14:1], 1'b1};
            // An even limit against an odd value never ties, so the held case cannot mislead the check.
            l = (t == 0) ? v - 16'h0001 : (t == 1) ? v + 16'h0001 : {r[30:16], 1'b0};
            measVal[k] = v;
            measLimit[k] = l;
            step(2);
            chk((k == 4) ? (v < l) : (v > l), noticeFlags[(k == 5) ? 7 : k + 1]);
         end
         measVal[k] = (k == 4) ? 16'h0001 : 16'h0000;
         measLimit[k] = (k == 4) ? 16'h0000 : 16'h0001;
      end
      $display("Test thresholds done");
      for (int i = 0; i < 8; i++) begin
         ioSel = i[2:0];
         r = $random(seed);
         ioBus = r[7:0];
         step(2);
         chk(ioBus[i], noticeFlags[0]);
      end
      ioBus = 8'h00;
      $display("Test assigned io done");
      for (int t = 0; t < 24; t++) begin
         r = $random(seed);
         {readyIn, startDirRev, stopIn} = r[7:0];
         if (t % 4 == 0) stopIn = 6'h00;
         if (t % 4 < 2) readyIn = 1'b1;
         pulse(startReq);
         chk(start_bad(readyIn, startDirRev, stopIn), noticeFlags[8]);
      end
      {readyIn, stopIn} = 7'h40;
      for (int t = 0; t < 12; t++) begin
         r = $random(seed);
         {coordValid, elHome} = (t % 3 == 0) ? 2'b10 : r[1:0];
         pulse(homeReq);
         chk(!coordValid || elHome, noticeFlags[9]);
      end
      coordValid = 1'b0;
      pulse(homeReq);
      pulse(startReq);
      chk(0, noticeFlags[9:8]);
      $display("Test start errors done");
      overloadIn = 1'b1;
      step(6);
      chk(0, noticeFlags[6]);
      step(14);
      chk(1, noticeFlags[6]);
      overloadIn = 1'b0;
      step(24);
      chk(0, noticeFlags[6]);
      $display("Test overload done");
      pulse(presetTrig);
      chk(11'h400, noticeFlags);
      for (int t = 0; t < 6; t++) begin
         r = $random(seed);
         actionSel = (t == 0) ? 11'h3FF : (t == 1) ? 11'h400 : r[10:0];
         step(2);
         chk(actionSel[10], infoOut);
      end
      // Any window of two blink periods holds the indicator high for exactly one period.
      actionSel = 11'h400;
      blinkHigh = 0;
      repeat (8 * ism_pkg::BLINK_TICKS) begin
         step(1);
         blinkHigh += ledBlink;
      end
      chk(4 * ism_pkg::BLINK_TICKS, blinkHigh);
      pulse(presetDone);
      chk(0, noticeFlags[10]);
      $display("Test preset and action done");
      i_ism_host_model.clear_hist();
      step(2);
      chk(0, histCount);
      for (int i = 1; i <= 18; i++) begin
         pulse(presetTrig);
         pulse(presetDone);
         chk((i > 16) ? 16 : i, histCount);
      end
      i_ism_host_model.read_rec(4'h0, ok);
      s0 = monStamp;
      chk(1, ok);
      chk({1'b1, 4'hB, 11'h400}, {monHit, monCode, monContents});
      i_ism_host_model.read_rec(4'hF, ok);
      chk(1, monHit && (s0 > monStamp));
      i_ism_host_model.clear_hist();
      step(2);
      chk(0, histCount);
      i_ism_host_model.read_rec(4'h0, ok);
      chk(0, {monHit, monCode});
      $display("Test history done");
      pulse(presetTrig);
      rst_b = 1'b0;
      step(2);
      rst_b = 1'b1;
      step(4);
      chk(0, {histCount, noticeFlags});
      $display("Test second reset done");
      end_of_test();
   end
endmodule : test_ism_info_monitor
